// ---- hdl/oar_addr_repeat.sv ----
/*
  oar_addr_repeat: operand address generation and instruction repeat
  control for a 16-bit fixed-point signal processor core.
  assumes: decoded instructions arrive with a valid strobe and wait while
  fetchReady is low; data memory returns the repeat count on a strobe.
  the second word of a two-word instruction rides on secondWord with the
  first; the core holds off every interrupt source while irqMasked is
  high; a repeat instruction only brings a direct, indirect or short
  immediate count, any other mode would wait in load for a memory word.
*/
// Contract
// - direct address is page joined with offset
// - indirect address from selected auxiliary register
// - pointer 0 to 7 picks register
// - seven indirect update kinds supported
// - address first, then register and pointer update
// - short immediate taken from instruction field
// - long immediate is second instruction word
// - register mode reads a CPU register
// - repeat loads counter from memory or immediate
// - count N runs next instruction N+1 times
// - reset clears repeat counter
// - repeat masks all interrupts until loop ends
// - repeated multicycle instructions issue every cycle
// - next instruction prefetched during execution
// - external operand adds extra cycles, except within a repeat loop
`timescale 1ns/1ns
module oar_addr_repeat
  import oar_pkg::*;
#(
  parameter logic [2:0] EXT_WAIT = EXT_WAIT_DEF
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // decoded instruction from fetch
  input  wire logic                   instrValid,
  input  wire oar_instr_type          instr,
  input  wire logic [ADDR_W-1:0]      secondWord,
  input  wire logic [ADDR_W-1:0]      cpuRegs [NUM_AR],
  // data page pointer loads
  input  wire logic                   pageLoad,
  input  wire logic [PAGE_W-1:0]      pageValue,
  // data memory side
  input  wire logic                   operandExternal,
  input  wire logic                   memDataValid,
  input  wire logic [ADDR_W-1:0]      memData,
  // interrupt request from outside
  input  wire logic                   irqIn,
  // operand toward data memory and the datapath
  output oar_operand_type             operand,
  output logic [ADDR_W-1:0]           regOperand,
  // fetch and interrupt control
  output logic                        fetchReady,
  output logic                        repeatActive,
  output logic                        irqMasked,
  // visible pointer and counter state
  output logic [RPT_W-1:0]            repeatCount,
  output logic [PAGE_W-1:0]           dataPage,
  output logic [ARP_W-1:0]            arPointer
);

  // controller states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOAD  = 4'b0010,
    ST_LOOP  = 4'b0100,
    ST_WAIT  = 4'b1000
  } oar_state_type;

  // bit reverse helper used for both reversed update directions
  // reversing both operands turns the carry chain end for end
  function automatic logic [ADDR_W-1:0] revBits(input logic [ADDR_W-1:0] v);
    for (int i = 0; i < ADDR_W; i++) begin
      revBits[i] = v[ADDR_W-1-i];
    end
  endfunction : revBits

  // state registers
  oar_state_type          state_q, state_d;
  logic [RPT_W-1:0]       rpt_q, rpt_d;        // repeat counter
  logic [PAGE_W-1:0]      page_q, page_d;      // data page pointer
  logic [ARP_W-1:0]       arp_q, arp_d;        // aux register pointer
  logic [2:0]             wait_q, wait_d;      // external stretch count
  oar_operand_type        opnd_q, opnd_d;
  logic [ADDR_W-1:0]      regOp_q, regOp_d;
  logic                   ready_q, ready_d;
  logic                   mask_q, mask_d;      // interrupt mask
  logic                   act_q, act_d;        // repeat loop running

  // aux register file wiring
  logic                   arWrEn;
  logic [ADDR_W-1:0]      arWrData;
  logic [ADDR_W-1:0]      arCur;
  logic [ADDR_W-1:0]      arIdx;

  // read and write both follow the pointer as it stands this cycle
  oar_ar_file #(
    .DEPTH (NUM_AR),
    .WIDTH (ADDR_W)
  ) uArFile (
    .clk     (clk),
    .resetn  (resetn),
    .wrEn    (arWrEn),
    .wrSel   (arp_q),
    .wrData  (arWrData),
    .rdSel   (arp_q),
    .rdData  (arCur),
    .idxData (arIdx)
  );

  // accepted instruction this cycle
  logic take;
  assign take = instrValid && ready_q;

  // indirect post-update, computed after the address is used
  // the write lands at the next edge, after this cycle's read
  always_comb begin
    arWrEn   = take && (instr.mode == MODE_INDIRECT)
               && (instr.update != UPD_NONE);
    arWrData = arCur;
    unique case (instr.update)
      UPD_NONE:    arWrData = arCur;
      UPD_INC:     arWrData = arCur + 16'h0001;
      UPD_DEC:     arWrData = arCur - 16'h0001;
      UPD_ADD0:    arWrData = arCur + arIdx;
      UPD_SUB0:    arWrData = arCur - arIdx;
      // reverse, add, reverse back: carry runs msb toward lsb
      UPD_BRV_INC: arWrData = revBits(revBits(arCur) + revBits(arIdx));
      UPD_BRV_DEC: arWrData = revBits(revBits(arCur) - revBits(arIdx));
      default:     arWrData = arCur;  // unused encoding leaves it alone
    endcase
  end

  // operand formation, pointer, page and repeat control
  always_comb begin
    state_d = state_q;
    rpt_d   = rpt_q;
    page_d  = page_q;
    arp_d   = arp_q;
    wait_d  = wait_q;
    opnd_d  = opnd_q;
    regOp_d = regOp_q;
    ready_d = ready_q;
    mask_d  = mask_q;
    opnd_d.valid = 1'b0;
    if (pageLoad) begin
      page_d = pageValue;
    end
    unique case (state_q)
      ST_IDLE: begin
        // idle: one instruction a cycle while the next one is fetched
        ready_d = 1'b1;
        if (take) begin
          // address formed from state as it stood this cycle
          opnd_d.valid = 1'b1;
          opnd_d.isImm = 1'b0;
          unique case (instr.mode)
            MODE_DIRECT: begin
              opnd_d.addr = {page_q, instr.offset};
            end
            MODE_INDIRECT: begin
              // register as it stood before this access's update
              opnd_d.addr = arCur;
            end
            MODE_SHORTIMM: begin
              opnd_d.isImm   = 1'b1;
              opnd_d.immData = {8'h00, instr.shortImm};
            end
            MODE_LONGIMM: begin
              // second word arrives together with the first
              opnd_d.isImm   = 1'b1;
              opnd_d.immData = secondWord;
            end
            MODE_REGISTER: begin
              // no memory address needed
              opnd_d.valid = 1'b0;
              regOp_d = cpuRegs[instr.regSel];
            end
            default: begin
              opnd_d.valid = 1'b0;  // illegal mode fetches nothing
            end
          endcase
          // pointer changes only after the current access
          if (instr.mode == MODE_INDIRECT && instr.loadArp) begin
            arp_d = instr.nextArp;
          end
          // repeat: close interrupts first, then fetch the count
          if (instr.isRepeat) begin
            mask_d  = 1'b1;
            ready_d = 1'b0;
            if (instr.mode == MODE_SHORTIMM) begin
              rpt_d   = {8'h00, instr.shortImm};
              ready_d = 1'b1;
              state_d = ST_LOOP;
            end else begin
              state_d = ST_LOAD;
            end
          end else if (operandExternal &&
                       instr.mode inside {MODE_DIRECT, MODE_INDIRECT}) begin
            // off-chip operand shares the one data bus
            ready_d = 1'b0;
            wait_d  = EXT_WAIT;
            state_d = ST_WAIT;
          end
        end
      end
      ST_LOAD: begin
        // count word arrives from data memory
        if (memDataValid) begin
          // count word taken in the cycle it stands
          rpt_d   = memData;
          ready_d = 1'b1;
          state_d = ST_LOOP;
        end
      end
      ST_LOOP: begin
        // each accepted issue is one run; multicycle ops pipelined
        ready_d = 1'b1;
        if (take) begin
          // the run taken at zero is the last; interrupts reopen
          if (rpt_q == RPT_RST) begin
            mask_d  = 1'b0;
            state_d = ST_IDLE;
          end else begin
            rpt_d = rpt_q - 16'h0001;
          end
          opnd_d.valid = (instr.mode != MODE_REGISTER);
          opnd_d.isImm = 1'b0;
          opnd_d.addr  = (instr.mode == MODE_DIRECT) ?
                         {page_q, instr.offset} : arCur;
          // repeated indirect access still steps the pointer
          if (instr.mode == MODE_INDIRECT && instr.loadArp) begin
            arp_d = instr.nextArp;
          end
          // register operand refreshed on every run
          if (instr.mode == MODE_REGISTER) begin
            regOp_d = cpuRegs[instr.regSel];
          end
        end
      end
      ST_WAIT: begin
        // shared data bus: hold off the next instruction
        // a zero setting still costs one cycle
        if (wait_q == 3'h1 || wait_q == 3'h0) begin
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end else begin
          wait_d = wait_q - 3'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;  // recover from a corrupt code
        ready_d = 1'b1;
      end
    endcase
    // loop flag registered on its own so the output needs no decode
    act_d = (state_d == ST_LOOP) || (state_d == ST_LOAD);
  end

  // register everything; reset clears counter and pointers
  // counter and mask clear at once on reset, with no clock needed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      rpt_q   <= RPT_RST;
      page_q  <= PAGE_RST;
      arp_q   <= ARP_RST;
      wait_q  <= 3'h0;
      opnd_q  <= '0;
      regOp_q <= 16'h0000;
      ready_q <= 1'b0;
      mask_q  <= 1'b0;
      act_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      rpt_q   <= rpt_d;
      page_q  <= page_d;
      arp_q   <= arp_d;
      wait_q  <= wait_d;
      opnd_q  <= opnd_d;
      regOp_q <= regOp_d;
      ready_q <= ready_d;
      mask_q  <= mask_d;
      act_q   <= act_d;
    end
  end

  // irqIn passes through outside; the mask tells the core to hold it
  logic irqUnused;
  assign irqUnused = irqIn;

  // outputs straight from flops
  assign operand      = opnd_q;
  assign regOperand   = regOp_q;
  assign fetchReady   = ready_q;
  assign repeatActive = act_q;
  assign irqMasked    = mask_q;
  assign repeatCount  = rpt_q;
  assign dataPage     = page_q;
  assign arPointer    = arp_q;

endmodule : oar_addr_repeat

// ---- hdl/oar_ar_file.sv ----
/*
  oar_ar_file: the eight auxiliary address registers with one write port
  and a combinational read port plus the index register tap.
  assumes: single clock, asynchronous active low reset.
*/
`timescale 1ns/1ns
module oar_ar_file
  import oar_pkg::*;
#(
  parameter int DEPTH = NUM_AR,
  parameter int WIDTH = ADDR_W
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // write port
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrSel,
  input  wire logic [WIDTH-1:0]         wrData,
  // read port
  input  wire logic [$clog2(DEPTH)-1:0] rdSel,
  output logic      [WIDTH-1:0]         rdData,
  output logic      [WIDTH-1:0]         idxData
);

  logic [WIDTH-1:0] mem_q [DEPTH];  // register storage
  logic [WIDTH-1:0] mem_d [DEPTH];

  // next value for each register
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wrEn) begin
      mem_d[wrSel] = wrData;
    end
  end

  // write-through bypass avoided on purpose: callers read before update
  generate
    for (genvar g = 0; g < DEPTH; g++) begin : gReg
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          mem_q[g] <= AR_RST;
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
    end
  endgenerate

  // combinational taps of the current state
  assign rdData  = mem_q[rdSel];
  assign idxData = mem_q[0];

endmodule : oar_ar_file

// ---- hdl/oar_pkg.sv ----
/*
  oar_pkg: shared constants and carrier types for the operand addressing
  and repeat control block.
  assumes: included before every other design file of the block.
*/
package oar_pkg;

  // address and field widths
  localparam int ADDR_W      = 16;  // data-memory address width
  localparam int PAGE_W      = 9;   // data page pointer width
  localparam int OFFS_W      = 7;   // direct offset carried in the opcode
  localparam int NUM_AR      = 8;   // auxiliary address registers
  localparam int ARP_W       = 3;   // auxiliary register pointer width
  localparam int SHORT_IMM_W = 8;   // short immediate field width
  localparam int RPT_W       = 16;  // repeat counter width

  // reset values
  localparam logic [RPT_W-1:0]  RPT_RST  = 16'h0000;
  localparam logic [PAGE_W-1:0] PAGE_RST = 9'h000;
  localparam logic [ARP_W-1:0]  ARP_RST  = 3'h0;
  localparam logic [ADDR_W-1:0] AR_RST   = 16'h0000;

  // extra cycles added when a data operand lives off chip
  localparam logic [2:0] EXT_WAIT_DEF = 3'h1;

  // operand addressing modes
  typedef enum logic [2:0] {
    MODE_DIRECT   = 3'h0,
    MODE_INDIRECT = 3'h1,
    MODE_SHORTIMM = 3'h2,
    MODE_LONGIMM  = 3'h3,
    MODE_REGISTER = 3'h4
  } oar_mode_type;

  // indirect update kinds
  typedef enum logic [2:0] {
    UPD_NONE    = 3'h0,
    UPD_INC     = 3'h1,
    UPD_DEC     = 3'h2,
    UPD_ADD0    = 3'h3,
    UPD_SUB0    = 3'h4,
    UPD_BRV_INC = 3'h5,
    UPD_BRV_DEC = 3'h6
  } oar_update_type;

  // one decoded instruction from the fetch path
  typedef struct packed {
    oar_mode_type       mode;
    oar_update_type     update;
    logic               loadArp;    // load pointer after the access
    logic [ARP_W-1:0]   nextArp;
    logic [OFFS_W-1:0]  offset;     // direct low address bits
    logic [SHORT_IMM_W-1:0] shortImm;
    logic [ARP_W-1:0]   regSel;     // register-mode source
    logic               isRepeat;   // repeat instruction
    logic               multiCycle; // normally multicycle
  } oar_instr_type;

  // operand request toward data memory
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic              isImm;
    logic [ADDR_W-1:0] immData;
  } oar_operand_type;

endpackage : oar_pkg

// ---- test/oar_addr_repeat_tb.sv ----
/* oar_addr_repeat_tb: random and corner tests of the block.
   assumes: oar_mem_model stands as data memory. */
`timescale 1ns/1ns
module oar_addr_repeat_tb;
  import oar_pkg::*;
  localparam logic [2:0] EW = 3'h2; // longer than default on purpose
  logic clk = 0, resetn = 1, instrValid = 0, pageLoad = 0, irqIn = 0;
  logic operandExternal = 0, arm = 0;
  logic [1:0] latency = 0;
  logic [8:0] pageValue = 0, page = 0;
  logic [15:0] secondWord = 0, regs [NUM_AR] = '{default: 0};
  logic [15:0] ar [NUM_AR] = '{default: 0}, memData, regOperand, repeatCount;
  logic [2:0] ptr = 0, arPointer;
  logic [8:0] dataPage;
  logic memDataValid, fetchReady, repeatActive, irqMasked;
  oar_instr_type instr = '0;
  oar_operand_type operand;
  int cyc = 0, mismatches = 0, compares = 0;
  always #5 clk = ~clk;
  oar_addr_repeat #(.EXT_WAIT(EW)) i_dut (.clk(clk), .resetn(resetn),
    .instrValid(instrValid), .instr(instr), .secondWord(secondWord),
    .cpuRegs(regs), .pageLoad(pageLoad), .pageValue(pageValue),
    .operandExternal(operandExternal), .memDataValid(memDataValid),
    .memData(memData), .irqIn(irqIn), .operand(operand),
    .regOperand(regOperand), .fetchReady(fetchReady),
    .repeatActive(repeatActive), .irqMasked(irqMasked),
    .repeatCount(repeatCount), .dataPage(dataPage), .arPointer(arPointer));
  oar_mem_model i_mem (.clk(clk), .resetn(resetn), .arm(arm),
    .latency(latency), .operand(operand), .memDataValid(memDataValid),
    .memData(memData));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // hang guard, tests need well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chkV(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chkV
  task automatic chkB(string n, logic e, logic g);
    chkV(n, {15'h0, e}, {15'h0, g});
  endtask : chkB
  function automatic logic [15:0] rev(logic [15:0] a);
    for (int b = 0; b < 16; b++) rev[b] = a[15-b];
  endfunction : rev
  // expected auxiliary register after an update
  function automatic logic [15:0] upd(oar_update_type u, logic [15:0] a, x);
    case (u)
      UPD_INC: return a + 16'h1;
      UPD_DEC: return a - 16'h1;
      UPD_ADD0: return a + x;
      UPD_SUB0: return a - x;
      UPD_BRV_INC: return rev(rev(a) + rev(x));
      UPD_BRV_DEC: return rev(rev(a) - rev(x));
      default: return a;
    endcase
  endfunction : upd
  // valid stays high on return so takes run back to back
  task automatic take(oar_instr_type i);
    bit ok;
    ok = 0;
    instr = i;
    instrValid = 1;
    for (int k = 0; k < 40 && !ok; k++) begin
      @(posedge clk);
      ok = (fetchReady === 1'b1);
    end
    #1;
    chkB("accepted", 1'b1, ok);
  endtask : take
  task automatic setPage();
    instrValid = 0;
    pageLoad = 1;
    pageValue = 9'($urandom);
    page = pageValue;
    @(posedge clk);
    #1;
    pageLoad = 0;
    chkV("page", {7'h0, page}, {7'h0, dataPage});
    chkV("pointer", {13'h0, ptr}, {13'h0, arPointer});
  endtask : setPage
  task automatic randOp();
    oar_instr_type i;
    i = '0;
    i.mode = oar_mode_type'(3'($urandom_range(4)));
    i.offset = 7'($urandom);
    i.shortImm = 8'($urandom);
    i.regSel = 3'($urandom);
    i.multiCycle = 1'($urandom);
    secondWord = 16'($urandom);
    foreach (regs[r]) regs[r] = 16'($urandom);
    if (i.mode == MODE_INDIRECT) begin
      i.update = oar_update_type'(3'($urandom_range(6)));
      i.loadArp = 1'($urandom);
      i.nextArp = 3'($urandom);
    end
    take(i);
    chkB("valid", i.mode != MODE_REGISTER, operand.valid);
    case (i.mode)
      MODE_DIRECT: chkV("direct", {page, i.offset}, operand.addr);
      MODE_INDIRECT: begin
        chkV("indirect", ar[ptr], operand.addr);
        ar[ptr] = upd(i.update, ar[ptr], ar[0]);
        if (i.loadArp) ptr = i.nextArp;
      end
      MODE_SHORTIMM: chkV("short", {8'h0, i.shortImm}, operand.immData);
      MODE_LONGIMM: chkV("long", secondWord, operand.immData);
      default: chkV("register", regs[i.regSel], regOperand);
    endcase
  endtask : randOp
  // runs the n+1 repeated takes after a counter load
  task automatic runLoop(int n);
    int c0;
    oar_instr_type i;
    i = '0;
    i.multiCycle = 1;
    irqIn = 1;
    c0 = cyc;
    for (int k = 0; k <= n; k++) begin
      chkB("active", 1'b1, repeatActive);
      chkB("masked", 1'b1, irqMasked);
      take(i);
    end
    chkV("loop cycles", 16'(n + 1), 16'(cyc - c0));
    chkB("active end", 1'b0, repeatActive);
    chkB("mask end", 1'b0, irqMasked);
    instrValid = 0;
    irqIn = 0;
  endtask : runLoop
  task automatic rptImm(int n);
    oar_instr_type i;
    i = '0;
    i.mode = MODE_SHORTIMM;
    i.isRepeat = 1;
    i.shortImm = 8'(n);
    take(i);
    chkV("count imm", 16'(n), repeatCount);
    runLoop(n);
  endtask : rptImm
  task automatic rptMem(int lat, bit sel);
    oar_instr_type i;
    int n;
    i = '0;
    i.isRepeat = 1;
    i.mode = sel ? MODE_INDIRECT : MODE_DIRECT;
    i.offset = 7'($urandom);
    n = sel ? ar[ptr][2:0] : i.offset[2:0];
    latency = 2'(lat);
    take(i);
    // armed after the take so a stale loop operand is never read
    arm = 1;
    instrValid = 0;
    for (int k = 0; k < 20 && fetchReady !== 1'b1; k++) @(posedge clk) #1;
    arm = 0;
    chkV("count mem", 16'(n), repeatCount);
    runLoop(n);
  endtask : rptMem
  task automatic extOp();
    oar_instr_type i;
    int w;
    i = '0;
    w = 0;
    operandExternal = 1;
    take(i);
    instrValid = 0;
    operandExternal = 0;
    while (fetchReady !== 1'b1 && w < 20) begin
      @(posedge clk) #1;
      w++;
    end
    chkV("ext wait", 16'(EW), 16'(w));
  endtask : extOp
  task automatic midReset();
    oar_instr_type i;
    i = '0;
    i.mode = MODE_SHORTIMM;
    i.isRepeat = 1;
    i.shortImm = 8'h05;
    take(i);
    i = '0;
    take(i);
    instrValid = 0;
    resetn = 0;
    #1;
    chkV("count clr", 16'h0, repeatCount);
    chkB("mask clr", 1'b0, irqMasked);
    @(posedge clk) #1 resetn = 1;
    ar = '{default: 0};
    ptr = 0;
    page = 0;
  endtask : midReset
  initial begin
    void'($urandom(61983));
    // a real falling edge so the async reset acts before the first clock
    #1 resetn = 0;
    repeat (5) @(posedge clk);
    chkV("count rst", 16'h0, repeatCount);
    #1 resetn = 1;
    for (int t = 0; t < 400; t++) begin
      if (t % 8 == 0) setPage();
      if (t % 60 == 0) extOp();
      if (t == 200) midReset();
      randOp();
    end
    foreach (ar[r]) rptImm(r == 7 ? 255 : r);
    for (int l = 0; l < 4; l++) rptMem(l, l[0]);
    complete_run();
  end
endmodule : oar_addr_repeat_tb

// ---- test/oar_checker.sv ----
/* oar_checker: port-level checks of oar_addr_repeat.
   assumes: bound to the top module, one clock, async low reset. */
`timescale 1ns/1ns
module oar_checker
  import oar_pkg::*;
#(parameter logic [2:0] EXT_WAIT = EXT_WAIT_DEF) (
  // clock and reset
  input wire logic            clk,
  input wire logic            resetn,
  // stimulus side
  input wire logic            instrValid,
  input wire oar_instr_type   instr,
  input wire logic [15:0]     secondWord,
  input wire logic [15:0]     cpuRegs [NUM_AR],
  input wire logic            operandExternal,
  input wire logic            memDataValid,
  input wire logic [15:0]     memData,
  // design outputs
  input wire oar_operand_type operand,
  input wire logic [15:0]     regOperand,
  input wire logic            fetchReady,
  input wire logic            repeatActive,
  input wire logic            irqMasked,
  input wire logic [15:0]     repeatCount,
  input wire logic [8:0]      dataPage,
  input wire logic [2:0]      arPointer
);
  localparam int EW = int'(EXT_WAIT); // wait length as a plain int
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take; // instruction accepted at this edge
  assign take = instrValid && fetchReady;
  chk_direct_addr: assert property (take && instr.mode == MODE_DIRECT |=>
    operand.valid && operand.addr == {$past(dataPage), $past(instr.offset)})
    else $error("direct address wrong");
  chk_short_imm: assert property (take && instr.mode == MODE_SHORTIMM &&
    !instr.isRepeat |=> operand.isImm &&
    operand.immData == {8'h00, $past(instr.shortImm)})
    else $error("short immediate wrong");
  chk_long_imm: assert property (take && instr.mode == MODE_LONGIMM |=>
    operand.immData == $past(secondWord)) else $error("long imm wrong");
  chk_reg_mode: assert property (take && instr.mode == MODE_REGISTER |=>
    regOperand == $past(cpuRegs[instr.regSel])) else $error("reg operand");
  chk_rpt_load: assert property (take && instr.isRepeat &&
    instr.mode == MODE_SHORTIMM && !repeatActive |=> repeatActive &&
    irqMasked && repeatCount == {8'h00, $past(instr.shortImm)})
    else $error("repeat load wrong");
  chk_mem_count: assert property (memDataValid |=>
    repeatCount == $past(memData)) else $error("memory count wrong");
  chk_count_dec: assert property (take && repeatActive &&
    repeatCount != 16'h0000 |=> repeatCount == $past(repeatCount) - 16'h1)
    else $error("count not decremented");
  chk_loop_end: assert property (take && repeatActive &&
    repeatCount == 16'h0000 |=> !repeatActive && !irqMasked)
    else $error("loop did not end");
  chk_mask_hold: assert property (repeatActive |-> irqMasked)
    else $error("interrupts open in loop");
  chk_loop_pipe: assert property (take && repeatActive &&
    !operandExternal && repeatCount != 16'h0000 |=> fetchReady)
    else $error("repeat loop stalled");
  chk_ext_wait: assert property (take && operandExternal &&
    !instr.isRepeat |=> !fetchReady ##EW fetchReady)
    else $error("external wait wrong");
  chk_reset_clear: assert property (disable iff (1'b0) !resetn |->
    repeatCount == 16'h0000 && !irqMasked) else $error("reset not clear");
  chk_ptr_load: assert property (take && instr.mode == MODE_INDIRECT &&
    instr.loadArp |=> arPointer == $past(instr.nextArp))
    else $error("pointer not loaded");
  // main scenarios reached
  cov_loop_end: cover property (take && repeatActive &&
    repeatCount == 16'h0000);
  cov_mem_load: cover property (memDataValid);
  cov_ext: cover property (take && operandExternal);
endmodule : oar_checker

bind oar_addr_repeat oar_checker #(.EXT_WAIT(EXT_WAIT)) i_chk (
  .clk(clk), .resetn(resetn), .instrValid(instrValid), .instr(instr),
  .secondWord(secondWord), .cpuRegs(cpuRegs), .memData(memData),
  .operandExternal(operandExternal), .memDataValid(memDataValid),
  .operand(operand), .regOperand(regOperand), .fetchReady(fetchReady),
  .repeatActive(repeatActive), .irqMasked(irqMasked),
  .repeatCount(repeatCount), .dataPage(dataPage), .arPointer(arPointer));

// ---- test/oar_mem_model.sv ----
/* oar_mem_model: data memory answering repeat-count reads.
   assumes: armed by the bench only around a repeat load. */
`timescale 1ns/1ns
module oar_mem_model
  import oar_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            resetn,
  // control from the bench
  input  wire logic            arm,
  input  wire logic [1:0]      latency,
  // request and answer
  input  wire oar_operand_type operand,
  output logic                 memDataValid,
  output logic [15:0]          memData
);
  logic        pend; // read waiting for its answer
  logic [1:0]  cnt;  // remaining wait cycles
  logic [15:0] addr; // captured read address
  // word at an address is its low three bits, keeps loops short
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend <= 1'b0;
      cnt <= 2'h0;
      addr <= 16'h0000;
      memDataValid <= 1'b0;
      memData <= 16'h5a5a;
    end else begin
      memDataValid <= 1'b0;
      memData <= ~memData; // released bus never holds a value
      if (arm && operand.valid) begin
        pend <= 1'b1;
        cnt <= latency;
        addr <= operand.addr;
      end else if (pend && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (pend) begin
        pend <= 1'b0;
        memDataValid <= 1'b1;
        memData <= {13'h0000, addr[2:0]};
      end
    end
  end
endmodule : oar_mem_model
